/* include/nand_host_defs.vh */
// Constants for the NAND host controller: commands, operations, timing.
// Assumes a 100 MHz system clock; included by the ECC and host design files, not by the FIFO.
`ifndef NAND_HOST_DEFS_VH
`define NAND_HOST_DEFS_VH

// Clock rate and time-to-cycle conversion (least times round up)
`define CLK_MHZ          100
`define NS_UP(ns)        ((((ns) * `CLK_MHZ) + 999) / 1000)

// One strobe step; a bus cycle is three steps (low, low, high)
`define STEP_NS          30
`define STEP_CYC         `NS_UP(`STEP_NS)
// Wait from the last command edge before ready/busy is trusted
`define WB_NS            100
`define WB_CYC           `NS_UP(`WB_NS)
// Longest array-to-register transfer (rounds down, exact here)
`define RBUSY_US         25
`define RBUSY_CYC        (`RBUSY_US * `CLK_MHZ)
// Typical block erase; busy limit default carries a margin of four
`define ERASE_MS         4
`define ERASE_CYC        (`ERASE_MS * 1000 * `CLK_MHZ)
`define BUSY_LIMIT_DEF   (4 * `ERASE_CYC)

// Device commands
`define CMD_READ         8'h00
`define CMD_READ_GO      8'h30
`define CMD_COPY_GO      8'h35
`define CMD_RESET        8'hFF
`define CMD_STATUS       8'h70
`define CMD_PROG         8'h80
`define CMD_PROG_GO      8'h10
`define CMD_CACHE_GO     8'h15
`define CMD_COPY_PROG    8'h85
`define CMD_ERASE        8'h60
`define CMD_ERASE_GO     8'hD0
`define CMD_CACHE_RD     8'h31
`define CMD_CACHE_LAST   8'h3F

// Operation codes on the user port
`define OP_RESET         4'h0
`define OP_STATUS        4'h1
`define OP_READ          4'h2
`define OP_PROGRAM       4'h3
`define OP_ERASE         4'h4
`define OP_COPY_READ     4'h5
`define OP_COPY_PROG     4'h6
`define OP_CACHE_PROG    4'h7
`define OP_CACHE_READ    4'h8
`define OP_CACHE_LAST    4'h9

// Phase flag positions of an operation
`define F_ADDR           4
`define F_WDATA          3
`define F_CMD2           2
`define F_BUSY           1
`define F_RDATA          0

// Error correction codeword and FIFO shape
`define ECC_BYTES        528
`define FIFO_WIDTH       8
`define FIFO_DEPTH       16
`define FIFO_AW          4

`endif

/* hw/sync_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two matching AW.
`timescale 1ns/1ps
module sync_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_r;
   reg [AW-1:0]    rd_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   // Full and empty come straight from the fill count
   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage array
   always @(posedge clock) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   // Pointers and fill count
   always @(posedge clock) begin
      if (rst) begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // sync_fifo

/* hw/ecc528.v */
// Single-error-correcting check code over each 528-byte codeword.
// Assumes bytes arrive in order after a clear; one byte per valid.
`timescale 1ns/1ps
`include "nand_host_defs.vh"
module ecc528 (
   input  wire        clock,
   input  wire        rst,
   input  wire        clear,
   input  wire        byte_valid,
   input  wire [7:0]  byte_in,
   output wire [18:0] code,
   output wire        code_valid
);
   localparam [31:0] LAST = `ECC_BYTES - 1;
   reg  [9:0]  idx_r;
   reg  [7:0]  col_r;
   reg  [9:0]  line_r;
   reg         par_r;
   reg  [18:0] code_r;
   reg         code_v_r;
   wire        odd;
   wire [7:0]  col_n;
   wire [9:0]  line_n;

   // Byte parity selects whether the byte index joins the line code
   assign odd    = ^byte_in;
   assign col_n  = col_r ^ byte_in;
   assign line_n = odd ? (line_r ^ idx_r) : line_r;
   assign code       = code_r;
   assign code_valid = code_v_r;

   // Accumulate and publish {parity, line, column} per codeword
   always @(posedge clock) begin
      if (rst || clear) begin
         idx_r    <= 10'h000;
         col_r    <= 8'h00;
         line_r   <= 10'h000;
         par_r    <= 1'b0;
         code_r   <= 19'h00000;
         code_v_r <= 1'b0;
      end else begin
         code_v_r <= 1'b0;
         if (byte_valid) begin
            if (idx_r == LAST[9:0]) begin
               code_r   <= {par_r ^ odd, line_n, col_n};
               code_v_r <= 1'b1;
               idx_r    <= 10'h000;
               col_r    <= 8'h00;
               line_r   <= 10'h000;
               par_r    <= 1'b0;
            end else begin
               idx_r  <= idx_r + 10'h001;
               col_r  <= col_n;
               line_r <= line_n;
               par_r  <= par_r ^ odd;
            end
         end
      end
   end
endmodule // ecc528

/* hw/nand_host.v */
// NAND flash host controller: sequences command, address and data
// cycles on the multiplexed byte bus and waits on ready/busy.
// Assumes one 100 MHz clock; device pins are asynchronous to it.
// Functional notes
// - Command bytes go out with command latch high across input strobe rise.
// - Each address byte gets its own input strobe pulse with address latch high.
// - Write data goes out with both latch strobes low, captured on strobe rise.
// - Page load takes at most 25 us; data is read only after ready.
// - Output strobe cycle is never shorter than 25 ns.
// - Host computes a single-bit-correcting check code per 528-byte codeword on ecc_code; it applies no correction.
// - Four address bytes: two column then two row; erase uses row only.
// - Array operations use setup plus execute commands; reset, status and cache reads use one.
`timescale 1ns/1ps
`include "nand_host_defs.vh"
module nand_host #(
   parameter [31:0] BUSY_LIMIT = `BUSY_LIMIT_DEF
) (
   input  wire        clock,
   input  wire        rst,
   input  wire        op_valid,
   output wire        op_ready,
   input  wire [3:0]  op_code,
   input  wire [11:0] op_column,
   input  wire [15:0] op_row,
   input  wire [11:0] op_count,
   output wire        op_done,
   output wire        op_timeout,
   output wire [7:0]  status_byte,
   input  wire        wr_valid,
   output wire        wr_ready,
   input  wire [7:0]  wr_data,
   output wire        rd_valid,
   input  wire        rd_ready,
   output wire [7:0]  rd_data,
   output wire [18:0] ecc_code,
   output wire        ecc_valid,
   input  wire        allow_writes,
   input  wire        lock_at_powerup,
   output wire        chip_select_n,
   output wire        command_latch_strobe,
   output wire        address_latch_strobe,
   output wire        input_strobe_n,
   output wire        output_strobe_n,
   output wire        write_protect_n,
   output wire        protect_at_powerup,
   input  wire [7:0]  data_lines_in,
   output wire [7:0]  data_lines_out,
   output wire        data_lines_oe,
   input  wire        ready_busy_n
);
   localparam [3:0] ST_IDLE  = 4'h0;
   localparam [3:0] ST_CMD1  = 4'h1;
   localparam [3:0] ST_ADDR  = 4'h2;
   localparam [3:0] ST_WDATA = 4'h3;
   localparam [3:0] ST_CMD2  = 4'h4;
   localparam [3:0] ST_WAITB = 4'h5;
   localparam [3:0] ST_BUSY  = 4'h6;
   localparam [3:0] ST_RDATA = 4'h7;
   localparam [3:0] ST_DONE  = 4'h8;
   localparam [31:0] STEP_LAST = `STEP_CYC - 1;
   localparam [31:0] WB_LAST   = `WB_CYC - 1;
   localparam [31:0] RB_LAST   = `RBUSY_CYC - 1;
   localparam [31:0] BUSY_LAST = BUSY_LIMIT - 1;

   // Phase flags {addr, wdata, cmd2, busy, rdata} of each operation
   function [4:0] op_flags;
      input [3:0] op;
      begin
         case (op)
            `OP_RESET:      op_flags = 5'b00010;
            `OP_STATUS:     op_flags = 5'b00001;
            `OP_READ:       op_flags = 5'b10111;
            `OP_PROGRAM:    op_flags = 5'b11110;
            `OP_ERASE:      op_flags = 5'b10110;
            `OP_COPY_READ:  op_flags = 5'b10110;
            `OP_COPY_PROG:  op_flags = 5'b10110;
            `OP_CACHE_PROG: op_flags = 5'b11110;
            `OP_CACHE_READ: op_flags = 5'b00011;
            `OP_CACHE_LAST: op_flags = 5'b00011;
            default:        op_flags = 5'b00000;
         endcase
      end
   endfunction

   // Setup command byte
   function [7:0] cmd1_of;
      input [3:0] op;
      begin
         case (op)
            `OP_RESET:      cmd1_of = `CMD_RESET;
            `OP_READ:       cmd1_of = `CMD_READ;
            `OP_COPY_READ:  cmd1_of = `CMD_READ;
            `OP_PROGRAM:    cmd1_of = `CMD_PROG;
            `OP_CACHE_PROG: cmd1_of = `CMD_PROG;
            `OP_COPY_PROG:  cmd1_of = `CMD_COPY_PROG;
            `OP_ERASE:      cmd1_of = `CMD_ERASE;
            `OP_CACHE_READ: cmd1_of = `CMD_CACHE_RD;
            `OP_CACHE_LAST: cmd1_of = `CMD_CACHE_LAST;
            default:        cmd1_of = `CMD_STATUS;
         endcase
      end
   endfunction

   // Execute command byte
   function [7:0] cmd2_of;
      input [3:0] op;
      begin
         case (op)
            `OP_READ:       cmd2_of = `CMD_READ_GO;
            `OP_COPY_READ:  cmd2_of = `CMD_COPY_GO;
            `OP_CACHE_PROG: cmd2_of = `CMD_CACHE_GO;
            `OP_ERASE:      cmd2_of = `CMD_ERASE_GO;
            default:        cmd2_of = `CMD_PROG_GO;
         endcase
      end
   endfunction

   // Lowest later phase that this operation uses
   function [3:0] next_st;
      input [3:0] cur;
      input [4:0] fl;
      input       cnt_nz;
      integer s;
      reg     here;
      begin
         next_st = ST_DONE;
         for (s = 7; s >= 2; s = s - 1) begin
            case (s)
               2:       here = fl[`F_ADDR];
               3:       here = fl[`F_WDATA] && cnt_nz;
               4:       here = fl[`F_CMD2];
               5:       here = fl[`F_BUSY];
               7:       here = fl[`F_RDATA] && cnt_nz;
               default: here = 1'b0;
            endcase
            if (here && (s > cur)) begin
               next_st = s[3:0];
            end
         end
      end
   endfunction

   // Column bytes first, then row bytes
   function [7:0] addr_byte;
      input [1:0]  idx;
      input [11:0] col;
      input [15:0] row;
      begin
         case (idx)
            2'd0:    addr_byte = col[7:0];
            2'd1:    addr_byte = {4'h0, col[11:8]};
            2'd2:    addr_byte = row[7:0];
            default: addr_byte = row[15:8];
         endcase
      end
   endfunction

   reg  [3:0]  state_r;
   reg  [3:0]  op_r;
   reg  [4:0]  flags_r;
   reg  [11:0] col_r;
   reg  [15:0] row_r;
   reg  [11:0] cnt_r;
   reg  [1:0]  aidx_r;
   reg         act_r;
   reg  [3:0]  div_r;
   reg  [1:0]  ph_r;
   reg  [31:0] wait_r;
   reg         cs_n_r;
   reg         cle_r;
   reg         ale_r;
   reg         we_n_r;
   reg         re_n_r;
   reg         doe_r;
   reg  [7:0]  dout_r;
   reg  [7:0]  status_r;
   reg         done_r;
   reg         tmo_r;
   reg         wp_n_r;
   reg         strap_r;
   reg         rb_s1;
   reg         rb_s2;
   reg  [7:0]  di_s1;
   reg  [7:0]  di_s2;
   reg         ecc_clr_r;
   wire        tx_valid;
   wire [7:0]  tx_data;
   wire        rx_ready;
   wire        is_status;
   wire        start_ok;
   wire        start;
   wire        tick;
   wire        sample;
   wire        endc;
   wire        tx_pop;
   wire        rx_push;
   wire [3:0]  nxt;
   wire [31:0] limit;

   assign is_status = (op_r == `OP_STATUS);
   assign tick      = act_r && (div_r == STEP_LAST[3:0]);
   assign sample    = tick && (ph_r == 2'd1) && (state_r == ST_RDATA);
   assign endc      = tick && (ph_r == 2'd2);
   assign start_ok  = (state_r == ST_CMD1) || (state_r == ST_ADDR) ||
                      (state_r == ST_CMD2) ||
                      ((state_r == ST_WDATA) && tx_valid) ||
                      ((state_r == ST_RDATA) && (rx_ready || is_status));
   assign start     = !act_r && start_ok;
   assign tx_pop    = start && (state_r == ST_WDATA);
   assign rx_push   = sample && !is_status;
   assign nxt       = next_st(state_r, flags_r, cnt_r != 12'h000);
   assign limit     = flags_r[`F_RDATA] ? RB_LAST : BUSY_LAST;

   // Pin inputs pass two flip-flops before use
   always @(posedge clock) begin
      if (rst) begin
         rb_s1 <= 1'b0;
         rb_s2 <= 1'b0;
         di_s1 <= 8'h00;
         di_s2 <= 8'h00;
      end else begin
         rb_s1 <= ready_busy_n;
         rb_s2 <= rb_s1;
         di_s1 <= data_lines_in;
         di_s2 <= di_s1;
      end
   end

   // Bus cycle engine and operation sequencer
   always @(posedge clock) begin
      if (rst) begin
         state_r   <= ST_WAITB;
         op_r      <= `OP_RESET;
         flags_r   <= 5'b00000;
         col_r     <= 12'h000;
         row_r     <= 16'h0000;
         cnt_r     <= 12'h000;
         aidx_r    <= 2'd0;
         act_r     <= 1'b0;
         div_r     <= 4'h0;
         ph_r      <= 2'd0;
         wait_r    <= 32'h00000000;
         cs_n_r    <= 1'b1;
         cle_r     <= 1'b0;
         ale_r     <= 1'b0;
         we_n_r    <= 1'b1;
         re_n_r    <= 1'b1;
         doe_r     <= 1'b0;
         dout_r    <= 8'h00;
         status_r  <= 8'h00;
         done_r    <= 1'b0;
         tmo_r     <= 1'b0;
         wp_n_r    <= 1'b0;
         strap_r   <= 1'b0;
         ecc_clr_r <= 1'b0;
      end else begin
         done_r    <= 1'b0;
         ecc_clr_r <= 1'b0;
         wp_n_r    <= allow_writes;
         strap_r   <= lock_at_powerup;
         // Open a byte cycle: strobe falls, latches and data set up
         if (start) begin
            act_r  <= 1'b1;
            div_r  <= 4'h0;
            ph_r   <= 2'd0;
            cle_r  <= (state_r == ST_CMD1) || (state_r == ST_CMD2);
            ale_r  <= (state_r == ST_ADDR);
            if (state_r == ST_RDATA) begin
               re_n_r <= 1'b0;
            end else begin
               we_n_r <= 1'b0;
               doe_r  <= 1'b1;
               case (state_r)
                  ST_CMD1:  dout_r <= cmd1_of(op_r);
                  ST_CMD2:  dout_r <= cmd2_of(op_r);
                  ST_ADDR:  dout_r <= addr_byte(aidx_r, col_r, row_r);
                  default:  dout_r <= tx_data;
               endcase
            end
         end
         // Two low steps, then the strobe rises for the high step
         if (act_r) begin
            div_r <= tick ? 4'h0 : div_r + 4'h1;
            if (tick) begin
               ph_r <= ph_r + 2'd1;
            end
            if (tick && (ph_r == 2'd1)) begin
               we_n_r <= 1'b1;
               re_n_r <= 1'b1;
            end
            if (sample && is_status) begin
               status_r <= di_s2;
            end
            if (endc) begin
               act_r <= 1'b0;
               cle_r <= 1'b0;
               ale_r <= 1'b0;
               doe_r <= 1'b0;
               ph_r  <= 2'd0;
               case (state_r)
                  ST_ADDR: begin
                     if (aidx_r == 2'd3) begin
                        state_r <= nxt;
                     end else begin
                        aidx_r <= aidx_r + 2'd1;
                     end
                  end
                  ST_WDATA, ST_RDATA: begin
                     cnt_r <= cnt_r - 12'h001;
                     if (cnt_r == 12'h001) begin
                        state_r <= ST_DONE;
                        if (state_r == ST_WDATA) begin
                           state_r <= next_st(state_r, flags_r, 1'b0);
                        end
                     end
                  end
                  default: state_r <= nxt;
               endcase
            end
         end
         // Idle, busy wait and completion
         case (state_r)
            ST_IDLE: begin
               cs_n_r <= 1'b1;
               if (op_valid) begin
                  op_r      <= op_code;
                  flags_r   <= op_flags(op_code);
                  col_r     <= op_column;
                  row_r     <= op_row;
                  cnt_r     <= (op_code == `OP_STATUS) ? 12'h001 : op_count;
                  aidx_r    <= (op_code == `OP_ERASE) ? 2'd2 : 2'd0;
                  tmo_r     <= 1'b0;
                  cs_n_r    <= 1'b0;
                  ecc_clr_r <= 1'b1;
                  state_r   <= ST_CMD1;
               end
            end
            ST_WAITB: begin
               wait_r <= wait_r + 32'h00000001;
               if (wait_r == WB_LAST) begin
                  wait_r  <= 32'h00000000;
                  state_r <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               wait_r <= wait_r + 32'h00000001;
               if (rb_s2) begin
                  wait_r  <= 32'h00000000;
                  state_r <= nxt;
               end else if (wait_r == limit) begin
                  wait_r  <= 32'h00000000;
                  tmo_r   <= 1'b1;
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               done_r  <= 1'b1;
               cs_n_r  <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: begin
            end
         endcase
      end
   end

   // Write data path, filled by the user, drained by data cycles
   sync_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) tx_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (tx_valid),
      .out_ready (tx_pop),
      .out_data  (tx_data)
   );

   // Read data path; a full FIFO stalls the next output strobe
   sync_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) rx_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (rx_push),
      .in_ready  (rx_ready),
      .in_data   (di_s2),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   // Check code over every written and page-read data byte; status bytes are not included
   ecc528 ecc (
      .clock      (clock),
      .rst        (rst),
      .clear      (ecc_clr_r),
      .byte_valid (tx_pop || rx_push),
      .byte_in    (tx_pop ? tx_data : di_s2),
      .code       (ecc_code),
      .code_valid (ecc_valid)
   );

   // Pin and status outputs
   assign op_ready             = (state_r == ST_IDLE);
   assign op_done              = done_r;
   assign op_timeout           = tmo_r;
   assign status_byte          = status_r;
   assign chip_select_n        = cs_n_r;
   assign command_latch_strobe = cle_r;
   assign address_latch_strobe = ale_r;
   assign input_strobe_n       = we_n_r;
   assign output_strobe_n      = re_n_r;
   assign write_protect_n      = wp_n_r;
   assign protect_at_powerup   = strap_r;
   assign data_lines_out       = dout_r;
   assign data_lines_oe        = doe_r;
endmodule // nand_host

/* testbench/nand_host_monitor.sv */
// Checker for the NAND host pin sequencing and user handshake.
// Assumes it is bound to nand_host and sees only its ports.
`timescale 1ns/1ps
module nand_host_monitor (
   input wire clock,
   input wire rst,
   input wire op_done,
   input wire op_ready,
   input wire allow_writes,
   input wire chip_select_n,
   input wire command_latch_strobe,
   input wire address_latch_strobe,
   input wire input_strobe_n,
   input wire output_strobe_n,
   input wire write_protect_n,
   input wire data_lines_oe,
   input wire ready_busy_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_latch; !(command_latch_strobe && address_latch_strobe); endproperty
   a_latch: assert property (p_latch) else $error("both latches high");
   property p_sel; $fell(input_strobe_n) |-> !chip_select_n; endproperty
   a_sel: assert property (p_sel) else $error("strobe while deselected");
   property p_cmd; $rose(input_strobe_n) && command_latch_strobe |-> data_lines_oe; endproperty
   a_cmd: assert property (p_cmd) else $error("command edge undriven");
   property p_oe; data_lines_oe |-> output_strobe_n; endproperty
   a_oe: assert property (p_oe) else $error("drive during read");
   property p_rd; $fell(output_strobe_n) |-> !output_strobe_n [*6] ##1 output_strobe_n; endproperty
   a_rd: assert property (p_rd) else $error("read strobe width");
   property p_wp; !$past(rst) |-> write_protect_n == $past(allow_writes); endproperty
   a_wp: assert property (p_wp) else $error("protect pin lag");
   property p_busy; !ready_busy_n [*3] |-> input_strobe_n && output_strobe_n; endproperty
   a_busy: assert property (p_busy) else $error("strobe while busy");
   property p_done; op_done |-> op_ready && chip_select_n; endproperty
   a_done: assert property (p_done) else $error("no ready after done");
endmodule // nand_host_monitor
bind nand_host nand_host_monitor mon (.clock, .rst, .op_done, .op_ready, .allow_writes,
   .chip_select_n, .command_latch_strobe, .address_latch_strobe, .input_strobe_n,
   .output_strobe_n, .write_protect_n, .data_lines_oe, .ready_busy_n);

/* testbench/nand_model.sv */
// Behavioural NAND device: one 64-byte page, data register, status.
// Assumes host strobes; command busy time is scaled down to T_BUSY ns.
`timescale 1ns/1ps
module nand_model #(
   parameter T_BUSY = 1000
) (
   input  wire       cs_n,
   input  wire       cle,
   input  wire       ale,
   input  wire       we_n,
   input  wire       re_n,
   input  wire       wp_n,
   input  wire [7:0] din,
   output wire [7:0] dq,
   output reg        rb_n
);
   reg [7:0] pg [0:63];
   reg [7:0] dr [0:63];
   reg [7:0] q_r = 8'h00;
   reg [5:0] col = 6'h00;
   reg [1:0] na = 2'h0;
   reg       stat = 1'b0;
   reg       b;
   integer   i;
   // Power-up autoload of page 0 while busy
   initial begin
      for (i = 0; i < 64; i++) pg[i] = 8'hFF;
      rb_n = 1'b0;
      #1500 for (i = 0; i < 64; i++) dr[i] = pg[i];
      rb_n = 1'b1;
   end
   // Command, address and data capture on strobe rise
   always @(posedge we_n) if (!cs_n) begin
      b = 1'b0;
      if (cle) begin
         stat <= (din == 8'h70);
         na <= 2'h0;
         col <= 6'h00; // Cache reads restart the next page at column 0
         b = 1'b1;
         case (din)
            8'h10, 8'h15: if (wp_n) for (i = 0; i < 64; i++) pg[i] = dr[i];
            8'hD0: if (wp_n) for (i = 0; i < 64; i++) pg[i] = 8'hFF;
            8'h30, 8'h35, 8'h31, 8'h3F: for (i = 0; i < 64; i++) dr[i] = pg[i];
            default: b = 1'b0;
         endcase
         if (b) rb_n = 1'b0;
         if (b) rb_n <= #(T_BUSY) 1'b1;
      end else if (ale) begin
         if (na == 2'h0) col <= din[5:0];
         na <= na + 2'h1;
      end else begin
         dr[col] <= din;
         col <= col + 6'h01;
      end
   end
   // Byte out and column advance on output strobe fall
   always @(negedge re_n) if (!cs_n) begin
      q_r <= stat ? {wp_n, rb_n, 6'h00} : dr[col];
      if (!stat) col <= col + 6'h01;
   end
   // Drive only while selected and strobed, else the inverse of the last byte
   assign dq = (!cs_n && !re_n) ? q_r : ~q_r;
endmodule // nand_model

/* testbench/nand_host_tb.sv */
// Testbench for nand_host against the behavioural NAND model.
// Assumes nand_model and the bound checker; one 10 ns clock.
`timescale 1ns/1ps
module nand_host_tb;
   reg clock = 1'b0, rst = 1'b1, op_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
   reg allow_writes = 1'b1;
   reg [3:0] op_code = 4'h0;
   reg [11:0] op_count = 12'h000;
   reg [7:0] wr_data = 8'h00;
   integer failures = 0, n_tests = 0;
   wire op_ready, op_done, op_timeout, wr_ready, rd_valid, chip_select_n, data_lines_oe;
   wire command_latch_strobe, address_latch_strobe, input_strobe_n, output_strobe_n;
   wire write_protect_n, ready_busy_n, protect_at_powerup;
   wire [7:0] status_byte, rd_data, data_lines_in, data_lines_out, m_dq;
   always #5 clock = ~clock;
   nand_host #(.BUSY_LIMIT(32'd300)) uut (.clock, .rst, .op_valid, .op_ready, .op_code,
      .op_column(12'h000), .op_row(16'h0000), .op_count, .op_done, .op_timeout, .status_byte,
      .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .ecc_code(), .ecc_valid(),
      .allow_writes, .lock_at_powerup(!allow_writes), .chip_select_n, .command_latch_strobe,
      .address_latch_strobe, .input_strobe_n, .output_strobe_n, .write_protect_n,
      .protect_at_powerup, .data_lines_in, .data_lines_out, .data_lines_oe, .ready_busy_n);
   nand_model dev (.cs_n(chip_select_n), .cle(command_latch_strobe), .ale(address_latch_strobe),
      .we_n(input_strobe_n), .re_n(output_strobe_n), .wp_n(write_protect_n),
      .din(data_lines_in), .dq(m_dq), .rb_n(ready_busy_n));
   assign data_lines_in = data_lines_oe ? data_lines_out : m_dq;
   task chk(input string nm, input [7:0] s, input [7:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("mismatch %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task op(input [3:0] c, input [11:0] n);
      integer i;
      begin
         for (i = 0; op_ready !== 1'b1 && i < 5000; i++) @(negedge clock);
         op_code = c;
         op_count = n;
         op_valid = 1'b1;
         @(negedge clock);
         op_valid = 1'b0;
         for (i = 0; op_done !== 1'b1 && i < 5000; i++) @(negedge clock);
         chk("op_done", op_done, 8'h01);
         chk("op_timeout", op_timeout, 8'h00);
      end
   endtask
   task fill(input [7:0] k);
      integer i;
      begin
         for (i = 0; i < 16; i++) begin
            chk("wr_ready", wr_ready, 8'h01);
            wr_data = 8'(i * 3) + k;
            wr_valid = 1'b1;
            @(negedge clock);
         end
         wr_valid = 1'b0;
         chk("wr_full", wr_ready, 8'h00);
      end
   endtask
   task rdchk(input [3:0] c, input [7:0] k, input ff);
      integer i;
      begin
         op(c, 12'h010);
         rd_ready = 1'b1;
         for (i = 0; i < 16; i++) begin
            chk("rd_valid", rd_valid, 8'h01);
            chk("rd_data", rd_data, ff ? 8'hFF : 8'(i * 3) + k);
            @(negedge clock);
         end
         rd_ready = 1'b0;
         chk("rd_empty", rd_valid, 8'h00);
      end
   endtask
   task t_prog; begin fill(8'h01); op(4'h3, 12'h010); rdchk(4'h2, 8'h01, 1'b0); end endtask
   task t_status;
      begin
         op(4'h0, 12'h000);
         op(4'h1, 12'h000);
         chk("status", status_byte, 8'hC0);
         chk("strap_off", protect_at_powerup, 8'h00);
      end
   endtask
   task t_protect;
      begin
         allow_writes = 1'b0;
         op(4'h4, 12'h000);
         op(4'h1, 12'h000);
         chk("status_wp", status_byte, 8'h40);
         chk("strap_on", protect_at_powerup, 8'h01);
         chk("wp_pin", write_protect_n, 8'h00);
         rdchk(4'h2, 8'h01, 1'b0);
         allow_writes = 1'b1;
         op(4'h4, 12'h000);
         rdchk(4'h2, 8'h00, 1'b1);
      end
   endtask
   task t_copy;
      begin
         fill(8'h05);
         op(4'h3, 12'h010);
         op(4'h5, 12'h000);
         op(4'h4, 12'h000);
         op(4'h6, 12'h000);
         rdchk(4'h2, 8'h05, 1'b0);
      end
   endtask
   task t_cache;
      begin
         fill(8'h09);
         op(4'h7, 12'h010);
         rdchk(4'h8, 8'h09, 1'b0);
         rdchk(4'h9, 8'h09, 1'b0);
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (8) @(negedge clock);
      rst = 1'b0;
      t_prog();
      t_status();
      t_protect();
      t_copy();
      t_cache();
      stop_test();
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (60000) @(posedge clock);
      failures++;
      stop_test();
   end
endmodule // nand_host_tb
